// *** include/opslt_pkg.sv ***
// Purpose: Shared constants for the periodic priority point and low-speed
//          commit threshold register pair.
// Assumes: Byte addresses inside one controller function's memory space.
// Notes:   Every field position and reset value of the block lives here.

package opslt_pkg;

  // ---------------------------------------------------------------
  // Register bus geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;
  localparam int BYTE_W = 8;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_PERIODIC_PRIORITY_POINT = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_LOW_SPEED_COMMIT_THRESHOLD = 8'h44;

  // ---------------------------------------------------------------
  // Field layouts and reset values
  // ---------------------------------------------------------------
  localparam int FRAME_W = 14;
  localparam int PS_W = 14;
  localparam int PS_LSB = 0;
  localparam int LS_W = 12;
  localparam int LS_LSB = 0;
  localparam logic [PS_W-1:0] PS_RESET = 14'h0000;
  localparam logic [LS_W-1:0] LS_RESET = 12'h628;
  localparam logic [FRAME_W-1:0] FRAME_RESET = 14'h0000;
  localparam logic [FRAME_W-1:0] FRAME_ONE = 14'h0001;
  localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h00000000;

endpackage : opslt_pkg

// *** hw/opslt_frame_count.sv ***
// Purpose: Frame bits-left countdown that both thresholds compare against.
// Assumes: One clk cycle is one bit time; frame length comes from logic on
//          the same clock.
// Notes:   The zero state lasts one bit time, then the frame length reloads.

module opslt_frame_count
  import opslt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Frame length from the frame length register
  input wire logic [FRAME_W-1:0] frame_length,
  // Countdown state
  output logic [FRAME_W-1:0] frame_bits_left,
  output logic frame_wrap
);

  // ---------------------------------------------------------------
  // Countdown
  // ---------------------------------------------------------------
  logic [FRAME_W-1:0] count_ff;
  logic [FRAME_W-1:0] nxt_count;
  wire at_zero = (count_ff == FRAME_RESET);

  // Decrement each bit time, reload from zero at the next boundary.
  assign nxt_count = at_zero ? frame_length : count_ff - FRAME_ONE;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_ff <= FRAME_RESET;
    end else begin
      count_ff <= nxt_count;
    end
  end

  assign frame_bits_left = count_ff;
  assign frame_wrap = at_zero;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_CNT_DOWN: assert property (@(posedge clk) disable iff (rst)
    (count_ff != FRAME_RESET) |=> (count_ff == $past(count_ff) - FRAME_ONE))
    else $error("Frame countdown did not step down by one.");

  AST_CNT_RELOAD: assert property (@(posedge clk) disable iff (rst)
    (count_ff == FRAME_RESET) |=> (count_ff == $past(frame_length)))
    else $error("Frame countdown did not reload the frame length.");

endmodule : opslt_frame_count

// *** hw/opslt_top.sv ***
// Purpose: Periodic priority point and low-speed commit threshold registers
//          with the frame-time decisions that they steer.
// Assumes: clk is the bit-time clock; scheduler inputs share that clock.
// Notes:   Reserved bits are dropped on write and read back as zero.
//
// What this block does
// - 14-bit periodic priority field, upper bits reserved.
// - Periodic priority field clears on hardware reset.
// - Periodic lists win once countdown reaches point.
// - Running control or bulk transaction finishes first.
// - Threshold decides low-speed packet commit before frame end.
// - 12-bit threshold, reset 628h, upper bits reserved.
// - Low-speed start only while bits left are at least the threshold.
// - Scheduler logic never alters the threshold.
// - Countdown steps each bit time, reloads after zero.

module opslt_top
  import opslt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register access
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [BE_W-1:0] reg_be,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  // Frame timing
  input wire logic [FRAME_W-1:0] frame_length,
  output logic [FRAME_W-1:0] frame_bits_left,
  // Scheduler handshake
  input wire logic ctl_bulk_busy,
  output logic periodic_window,
  output logic periodic_go,
  output logic ctl_bulk_start_ok,
  output logic low_speed_start_ok
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Merge the enabled byte lanes of a write into the old word.
  function automatic logic [DATA_W-1:0] merge_bytes(
    input logic [DATA_W-1:0] old_word,
    input logic [DATA_W-1:0] new_word,
    input logic [BE_W-1:0] be
  );
    logic [DATA_W-1:0] res;
    res = old_word;
    for (int i = 0; i < BE_W; i++) begin
      if (be[i]) begin
        res[i*BYTE_W +: BYTE_W] = new_word[i*BYTE_W +: BYTE_W];
      end
    end
    return res;
  endfunction : merge_bytes

  // ---------------------------------------------------------------
  // Frame countdown
  // ---------------------------------------------------------------
  logic [FRAME_W-1:0] bits_left;
  logic frame_wrap;

  opslt_frame_count u_frame_count (
    .clk(clk),
    .rst(rst),
    .frame_length(frame_length),
    .frame_bits_left(bits_left),
    .frame_wrap(frame_wrap)
  );

  // ---------------------------------------------------------------
  // Register decode
  // ---------------------------------------------------------------
  logic [PS_W-1:0] prio_point_ff;
  logic [LS_W-1:0] ls_thresh_ff;
  logic [PS_W-1:0] nxt_prio_point;
  logic [LS_W-1:0] nxt_ls_thresh;
  logic [DATA_W-1:0] reg_rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;
  logic reg_rvalid_ff;

  wire sel_ps = (reg_addr == OFS_PERIODIC_PRIORITY_POINT);
  wire sel_ls = (reg_addr == OFS_LOW_SPEED_COMMIT_THRESHOLD);
  wire wr_ps = reg_wr && sel_ps;
  wire wr_ls = reg_wr && sel_ls;

  wire [DATA_W-1:0] ps_word = DATA_W'(prio_point_ff) << PS_LSB;
  wire [DATA_W-1:0] ls_word = DATA_W'(ls_thresh_ff) << LS_LSB;
  wire [DATA_W-1:0] ps_merged = merge_bytes(ps_word, reg_wdata, reg_be);
  wire [DATA_W-1:0] ls_merged = merge_bytes(ls_word, reg_wdata, reg_be);

  // Only the field bits are kept; reserved bits have no storage.
  assign nxt_prio_point = wr_ps ? ps_merged[PS_LSB +: PS_W]
                                : prio_point_ff;
  // Only a register write changes the threshold, never the scheduler.
  assign nxt_ls_thresh = wr_ls ? ls_merged[LS_LSB +: LS_W]
                               : ls_thresh_ff;
  // Unmapped offsets read as zero so probing software sees nothing stray.
  assign nxt_rdata = sel_ps ? ps_word : (sel_ls ? ls_word : RDATA_ZERO);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prio_point_ff <= PS_RESET;
      ls_thresh_ff <= LS_RESET;
    end else begin
      prio_point_ff <= nxt_prio_point;
      ls_thresh_ff <= nxt_ls_thresh;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata_ff <= RDATA_ZERO;
      reg_rvalid_ff <= 1'b0;
    end else begin
      reg_rdata_ff <= reg_rd ? nxt_rdata : RDATA_ZERO;
      reg_rvalid_ff <= reg_rd;
    end
  end

  // ---------------------------------------------------------------
  // Frame-time decisions
  // ---------------------------------------------------------------
  logic window_ff;
  logic go_ff;
  logic cb_ok_ff;
  logic ls_ok_ff;
  logic [FRAME_W-1:0] bits_left_ff;

  wire reached_point = (bits_left <= FRAME_W'(prio_point_ff));
  // The window survives until the countdown wraps into a new frame.
  wire nxt_window = frame_wrap ? 1'b0 : (window_ff | reached_point);
  // Periodic work waits for the running control or bulk transfer.
  wire nxt_go = nxt_window && !ctl_bulk_busy;
  wire nxt_cb_ok = !nxt_window;
  // The packet is at most eight bytes; the threshold covers its length.
  wire nxt_ls_ok = (bits_left >= FRAME_W'(ls_thresh_ff));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      window_ff <= 1'b0;
      go_ff <= 1'b0;
      cb_ok_ff <= 1'b1;
      ls_ok_ff <= 1'b0;
      bits_left_ff <= FRAME_RESET;
    end else begin
      window_ff <= nxt_window;
      go_ff <= nxt_go;
      cb_ok_ff <= nxt_cb_ok;
      ls_ok_ff <= nxt_ls_ok;
      bits_left_ff <= bits_left;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign reg_rdata = reg_rdata_ff;
  assign reg_rvalid = reg_rvalid_ff;
  assign frame_bits_left = bits_left_ff;
  assign periodic_window = window_ff;
  assign periodic_go = go_ff;
  assign ctl_bulk_start_ok = cb_ok_ff;
  assign low_speed_start_ok = ls_ok_ff;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  AST_PS_READBACK: assert property (@(posedge clk) disable iff (rst)
    (reg_rd && sel_ps && !reg_wr)
      |=> (reg_rdata_ff == {{(DATA_W-PS_W){1'b0}}, $past(prio_point_ff)}))
    else $error("Periodic point read back wrong or reserved bits set.");

  AST_PS_RESET: assert property (@(posedge clk)
    $fell(rst) |-> (prio_point_ff == PS_RESET))
    else $error("Periodic point not cleared by reset.");

  AST_LS_RESET: assert property (@(posedge clk)
    $fell(rst) |-> (ls_thresh_ff == LS_RESET))
    else $error("Low-speed threshold has wrong reset value.");

  AST_LS_HELD: assert property (@(posedge clk) disable iff (rst)
    !(reg_wr && sel_ls) |=> $stable(ls_thresh_ff))
    else $error("Low-speed threshold changed without a write.");

  AST_WINDOW_OPEN: assert property (@(posedge clk) disable iff (rst)
    (reached_point && !frame_wrap)
      |=> window_ff ##1 (window_ff || $past(frame_wrap)))
    else $error("Periodic window did not open at the point.");

  AST_WINDOW_CLOSE: assert property (@(posedge clk) disable iff (rst)
    frame_wrap |=> (!window_ff && cb_ok_ff))
    else $error("Periodic window survived the frame reload.");

  AST_NO_ABORT: assert property (@(posedge clk) disable iff (rst)
    ctl_bulk_busy |=> !go_ff)
    else $error("Periodic work started over a running transfer.");

  AST_GO_EXCL: assert property (@(posedge clk) disable iff (rst)
    go_ff |-> (window_ff && !cb_ok_ff))
    else $error("Periodic go outside the periodic window.");

  AST_LS_GATE: assert property (@(posedge clk) disable iff (rst)
    ##1 (ls_ok_ff == ($past(bits_left) >= FRAME_W'($past(ls_thresh_ff)))))
    else $error("Low-speed start decision disagrees with threshold.");

  AST_PS_HELD: assert property (@(posedge clk) disable iff (rst)
    !(reg_wr && sel_ps) |=> $stable(prio_point_ff))
    else $error("Periodic point changed without a write.");

  AST_LS_RSVD: assert property (@(posedge clk) disable iff (rst)
    (reg_rd && sel_ls) |=> (reg_rdata_ff[DATA_W-1:LS_W] == '0))
    else $error("Threshold read shows reserved bits set.");

endmodule : opslt_top

// *** verif/opslt_top_tb.sv ***
// Purpose: Self-checking bench for the priority point and threshold pair.
// Assumes: Inputs change on the falling edge; outputs are read there too.
// Notes:   Frame checks start at a frame boundary so the window is clean.

module opslt_top_tb
  import opslt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic [BE_W-1:0] reg_be = 4'h0;
  logic [DATA_W-1:0] reg_wdata = 32'h00000000;
  logic reg_rd = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic reg_rvalid;
  logic [FRAME_W-1:0] frame_length = 14'h0014;
  logic [FRAME_W-1:0] frame_bits_left;
  logic ctl_bulk_busy = 1'b0;
  logic periodic_window, periodic_go, ctl_bulk_start_ok, low_speed_start_ok;
  int err_total = 0;
  int total_checks = 0;
  logic [FRAME_W-1:0] prev_left;
  logic exp_win;

  always #4 clk = ~clk;

  opslt_top dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .frame_length(frame_length), .frame_bits_left(frame_bits_left),
    .ctl_bulk_busy(ctl_bulk_busy), .periodic_window(periodic_window),
    .periodic_go(periodic_go), .ctl_bulk_start_ok(ctl_bulk_start_ok),
    .low_speed_start_ok(low_speed_start_ok));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic stop_test();
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(logic [7:0] a, logic [3:0] be, logic [31:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_be = be;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr

  // The answer is registered, so it is read one cycle after the strobe.
  task automatic rd_chk(logic [7:0] a, logic [31:0] exp);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk("rvalid", 32'h00000001, {31'h0, reg_rvalid});
    chk("rdata", exp, reg_rdata);
  endtask : rd_chk

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(negedge clk);
    chk("window in reset", 32'h0, {31'h0, periodic_window});
    chk("cb_ok in reset", 32'h1, {31'h0, ctl_bulk_start_ok});
    rst = 1'b0;
    rd_chk(8'h40, 32'h00000000);
    rd_chk(8'h44, 32'h00000628);
    wr(8'h40, 4'hF, 32'h00003FFF);
    rd_chk(8'h40, 32'h00003FFF);
    wr(8'h40, 4'h3, 32'h00003E67);
    rd_chk(8'h40, 32'h00003E67);
    wr(8'h44, 4'hF, 32'h00000FFF);
    rd_chk(8'h44, 32'h00000FFF);
    wr(8'h44, 4'h1, 32'h00000008);
    rd_chk(8'h44, 32'h00000F08);
    wr(8'h48, 4'hF, 32'h12345678);
    rd_chk(8'h48, 32'h00000000);
    rd_chk(8'h44, 32'h00000F08);
    // A small threshold stands in for the driver's sized transfer time.
    wr(8'h44, 4'h3, 32'h00000008);
    wr(8'h40, 4'hF, 32'h00000005);
    for (int i = 0; i < 40 && frame_bits_left !== 14'h0; i++) begin
      @(negedge clk);
    end
    chk("frame sync", 32'h0, {18'h0, frame_bits_left});
    prev_left = frame_bits_left;
    for (int i = 0; i < 50; i++) begin
      @(negedge clk);
      chk("bits left", {18'h0, (prev_left != 14'h0) ? prev_left - 14'h1 :
        frame_length}, {18'h0, frame_bits_left});
      exp_win = frame_bits_left != 14'h0 && frame_bits_left <= 14'h5;
      chk("window", {31'h0, exp_win},
        {31'h0, periodic_window});
      chk("go", {31'h0, exp_win && !ctl_bulk_busy},
        {31'h0, periodic_go});
      chk("cb_ok", {31'h0, !exp_win},
        {31'h0, ctl_bulk_start_ok});
      chk("ls_ok", {31'h0, frame_bits_left >= 14'h8},
        {31'h0, low_speed_start_ok});
      prev_left = frame_bits_left;
      ctl_bulk_busy = (i % 5) < 2;
    end
    ctl_bulk_busy = 1'b0;
    rd_chk(8'h44, 32'h00000008);
    rd_chk(8'h40, 32'h00000005);
    stop_test();
  end

  // ---------------------------------------------------------------
  // Watchdog: the tests need well under a thousand cycles.
  // ---------------------------------------------------------------
  initial begin
    #20000;
    err_total++;
    stop_test();
  end

endmodule : opslt_top_tb
